// File: bci_pkg.sv
// Shared types and constants for the instruction timing block.
// Assumes an accumulator instruction set with 8-bit opcodes.
package bci_pkg;

  // Clock cycle counts of the instruction classes.
  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam logic [3:0] CYC_4 = 4'h4;
  localparam logic [3:0] CYC_5 = 4'h5;
  localparam logic [3:0] CYC_8 = 4'h8;

  // Instruction lengths in program bytes.
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // Opcodes that the checks refer to by name.
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_SPARE = 8'hA5;
  localparam logic [7:0] OP_ADD_RN = 8'h28;
  localparam logic [7:0] OP_ADD_IND = 8'h26;
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_CODE_DP = 8'h93;
  localparam logic [7:0] OP_LD_DP = 8'h90;
  localparam logic [7:0] OP_INC_DP = 8'hA3;
  localparam logic [7:0] OP_RET = 8'h22;
  localparam logic [7:0] OP_INTERRUPT_RETURN = 8'h32;
  localparam logic [7:0] OP_LONG_SUBROUTINE_CALL = 8'h12;
  localparam logic [3:0] HI_XWRITE = 4'hF;
  localparam logic [2:0] HI_XMOVE = 3'h7;

  // Broad class of an instruction.
  typedef enum logic [2:0] {
    CLS_ALU,
    CLS_MOVE,
    CLS_BOOL,
    CLS_BRANCH,
    CLS_XMOVE,
    CLS_CODE,
    CLS_MULDIV,
    CLS_NOP
  } bci_cls_t;

  // Target of an external space move.
  typedef enum logic [1:0] {
    XT_NONE,
    XT_ONCHIP,
    XT_OFFCHIP,
    XT_FLASH
  } bci_xtgt_t;

  // Static decode of one opcode.
  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] cycles;
    logic cond;
    bci_cls_t cls;
  } bci_dec_t;

  // Description of the instruction in execution.
  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] cycles;
    logic cond;
    logic taken;
    bci_cls_t cls;
    bci_xtgt_t xtgt;
    logic xwrite;
  } bci_info_t;

endpackage : bci_pkg

// File: bci_timing.sv
// Decode and cycle timing of the byte CPU core.
// Assumes the fetch logic presents one opcode at a time with the branch
// condition already resolved, all inputs synchronous to clk_i.
`timescale 1ns/1ns

module bci_timing
  import bci_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic issue_i,
  input wire logic [7:0] opcode_i,
  input wire logic cond_taken_i,
  input wire logic external_space_ram_onchip_i,
  input wire logic flash_wr_en_i,
  output logic ready_o,
  output logic done_o,
  output bci_info_t info_o
);

  // Builds one decode entry.
  function automatic bci_dec_t mk(input logic [1:0] b, input logic [3:0] c,
                                  input logic cnd, input bci_cls_t k);
    mk.bytes = b;
    mk.cycles = c;
    mk.cond = cnd;
    mk.cls = k;
  endfunction : mk

  // Maps an opcode to its length, base cycle count and class.
  function automatic bci_dec_t decode(input logic [7:0] op);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = op[7:4];
    lo = op[3:0];
    decode = mk(LEN_1, CYC_1, 1'b0, CLS_ALU);
    if (lo[3]) begin
      // Bank register operand forms.
      case (hi)
        4'h7, 4'h8, 4'hA: decode = mk(LEN_2, CYC_2, 1'b0, CLS_MOVE);
        4'hB: decode = mk(LEN_3, CYC_3, 1'b1, CLS_BRANCH);
        4'hD: decode = mk(LEN_2, CYC_2, 1'b1, CLS_BRANCH);
        4'hC, 4'hE, 4'hF: decode = mk(LEN_1, CYC_1, 1'b0, CLS_MOVE);
        default: decode = mk(LEN_1, CYC_1, 1'b0, CLS_ALU);
      endcase
    end else begin
      case (lo)
        4'h6, 4'h7: begin
          // Indirect pointer operand forms.
          case (hi)
            4'h7, 4'h8, 4'hA: decode = mk(LEN_2, CYC_2, 1'b0, CLS_MOVE);
            4'hB: decode = mk(LEN_3, CYC_4, 1'b1, CLS_BRANCH);
            4'hC, 4'hD, 4'hE, 4'hF: decode = mk(LEN_1, CYC_2, 1'b0, CLS_MOVE);
            default: decode = mk(LEN_1, CYC_2, 1'b0, CLS_ALU);
          endcase
        end
        4'h5: begin
          case (hi)
            4'h7, 4'h8: decode = mk(LEN_3, CYC_3, 1'b0, CLS_MOVE);
            4'hA: decode = mk(LEN_1, CYC_1, 1'b0, CLS_NOP);
            4'hB, 4'hD: decode = mk(LEN_3, CYC_3, 1'b1, CLS_BRANCH);
            4'hC, 4'hE, 4'hF: decode = mk(LEN_2, CYC_2, 1'b0, CLS_MOVE);
            default: decode = mk(LEN_2, CYC_2, 1'b0, CLS_ALU);
          endcase
        end
        4'h4: begin
          case (hi)
            4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF:
              decode = mk(LEN_1, CYC_1, 1'b0, CLS_ALU);
            4'h8: decode = mk(LEN_1, CYC_8, 1'b0, CLS_MULDIV);
            4'hA: decode = mk(LEN_1, CYC_4, 1'b0, CLS_MULDIV);
            4'hB: decode = mk(LEN_3, CYC_3, 1'b1, CLS_BRANCH);
            4'h7: decode = mk(LEN_2, CYC_2, 1'b0, CLS_MOVE);
            default: decode = mk(LEN_2, CYC_2, 1'b0, CLS_ALU);
          endcase
        end
        4'h3: begin
          case (hi)
            4'h4, 4'h5, 4'h6: decode = mk(LEN_3, CYC_3, 1'b0, CLS_ALU);
            4'h7: decode = mk(LEN_1, CYC_3, 1'b0, CLS_BRANCH);
            4'h8, 4'h9: decode = mk(LEN_1, CYC_3, 1'b0, CLS_CODE);
            4'hA: decode = mk(LEN_1, CYC_1, 1'b0, CLS_MOVE);
            4'hB, 4'hC, 4'hD: decode = mk(LEN_1, CYC_1, 1'b0, CLS_BOOL);
            4'hE, 4'hF: decode = mk(LEN_1, CYC_3, 1'b0, CLS_XMOVE);
            default: decode = mk(LEN_1, CYC_1, 1'b0, CLS_ALU);
          endcase
        end
        4'h2: begin
          case (hi)
            4'h0, 4'h1: decode = mk(LEN_3, CYC_4, 1'b0, CLS_BRANCH);
            4'h2, 4'h3: decode = mk(LEN_1, CYC_5, 1'b0, CLS_BRANCH);
            4'h4, 4'h5, 4'h6: decode = mk(LEN_2, CYC_2, 1'b0, CLS_ALU);
            4'hE, 4'hF: decode = mk(LEN_1, CYC_3, 1'b0, CLS_XMOVE);
            default: decode = mk(LEN_2, CYC_2, 1'b0, CLS_BOOL);
          endcase
        end
        4'h1: decode = mk(LEN_2, CYC_3, 1'b0, CLS_BRANCH);
        default: begin
          case (hi)
            4'h0: decode = mk(LEN_1, CYC_1, 1'b0, CLS_NOP);
            4'h1, 4'h2, 4'h3: decode = mk(LEN_3, CYC_3, 1'b1, CLS_BRANCH);
            4'h4, 4'h5, 4'h6, 4'h7:
              decode = mk(LEN_2, CYC_2, 1'b1, CLS_BRANCH);
            4'h8: decode = mk(LEN_2, CYC_3, 1'b0, CLS_BRANCH);
            4'h9: decode = mk(LEN_3, CYC_3, 1'b0, CLS_MOVE);
            4'hA, 4'hB: decode = mk(LEN_2, CYC_2, 1'b0, CLS_BOOL);
            4'hC, 4'hD: decode = mk(LEN_2, CYC_2, 1'b0, CLS_MOVE);
            default: decode = mk(LEN_1, CYC_3, 1'b0, CLS_XMOVE);
          endcase
        end
      endcase
    end
  endfunction : decode

  bci_dec_t dec;
  bci_info_t info_q;
  bci_info_t info_d;
  logic ready_q;
  logic ready_d;
  logic done_q;
  logic done_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] run_q;
  logic [3:0] run_d;
  logic take;

  // Opcode decode and acceptance of a new instruction.
  assign dec = decode(opcode_i);
  assign take = ready_q && issue_i;

  // Next state of the execution sequencer.
  always_comb begin
    info_d = info_q;
    ready_d = ready_q;
    done_d = 1'b0;
    cnt_d = cnt_q;
    run_d = run_q;
    if (take) begin
      info_d.bytes = dec.bytes;
      info_d.cond = dec.cond;
      info_d.taken = dec.cond && cond_taken_i;
      // A taken branch costs one cycle more than the untaken one.
      info_d.cycles = dec.cycles + {3'h0, dec.cond && cond_taken_i};
      info_d.cls = dec.cls;
      info_d.xwrite = (dec.cls == CLS_XMOVE) && (opcode_i[7:4] == HI_XWRITE);
      if (dec.cls != CLS_XMOVE) begin
        info_d.xtgt = XT_NONE;
      end else if (info_d.xwrite && flash_wr_en_i) begin
        info_d.xtgt = XT_FLASH;
      end else if (external_space_ram_onchip_i) begin
        info_d.xtgt = XT_ONCHIP;
      end else begin
        info_d.xtgt = XT_OFFCHIP;
      end
      run_d = CYC_1;
      if (info_d.cycles == CYC_1) begin
        done_d = 1'b1;
      end else begin
        ready_d = 1'b0;
        cnt_d = info_d.cycles - CYC_1;
      end
    end else if (!ready_q) begin
      // One count per clock, no machine cycle grouping.
      cnt_d = cnt_q - CYC_1;
      run_d = run_q + CYC_1;
      if (cnt_q == CYC_1) begin
        ready_d = 1'b1;
        done_d = 1'b1;
      end
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      info_q <= '0;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      cnt_q <= 4'h0;
      run_q <= 4'h0;
    end else begin
      info_q <= info_d;
      ready_q <= ready_d;
      done_q <= done_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  assign ready_o = ready_q;
  assign done_o = done_q;
  assign info_o = info_q;

  // Accepted instruction with a given opcode.
  sequence s_acc(logic [7:0] op);
    ready_o && issue_i && opcode_i == op;
  endsequence

  chk_div_eight: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_acc(OP_DIV) |=> (!done_o) [*7] ##1 done_o)
    else $error("divide not 8 cycles");
  chk_mul_four: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_acc(OP_MUL) |=> (!done_o) [*3] ##1 done_o)
    else $error("multiply not 4 cycles");
  chk_add_bank: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_acc(OP_ADD_RN) |=> done_o && info_o.bytes == LEN_1)
    else $error("bank register add not 1 cycle");
  chk_add_indirect: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_acc(OP_ADD_IND) |=> !done_o ##1 done_o)
    else $error("indirect add not 2 cycles");
  chk_code_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_acc(OP_CODE_DP) |=> (!done_o) [*2] ##1 done_o)
    else $error("code read not 3 cycles");
  chk_xmove_time: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ready_o && issue_i && opcode_i[7:5] == HI_XMOVE && !opcode_i[3] &&
    opcode_i[2:0] != 3'h1 && opcode_i[2:0] != 3'h4 &&
    opcode_i[2:0] != 3'h5 && opcode_i[2:0] != 3'h6 &&
    opcode_i[2:0] != 3'h7
    |=> (!done_o) [*2] ##1 done_o && info_o.cls == CLS_XMOVE)
    else $error("external move not 3 cycles");
  chk_ptr_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_acc(OP_LD_DP) |=> ##2 done_o && info_o.bytes == LEN_3)
    else $error("data pointer load wrong");
  chk_ptr_inc: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_acc(OP_INC_DP) |=> done_o && ready_o)
    else $error("data pointer increment not 1 cycle");
  chk_ret_five: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_acc(OP_RET) or s_acc(OP_INTERRUPT_RETURN) |=> (!ready_o) [*4] ##1 done_o)
    else $error("return not 5 cycles");
  chk_call_four: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_acc(OP_LONG_SUBROUTINE_CALL) |=> (!done_o) [*3] ##1 done_o)
    else $error("long call not 4 cycles");
  chk_spare_nop: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_acc(OP_SPARE) |=> done_o && info_o.cls == CLS_NOP)
    else $error("spare opcode not a no-operation");
  chk_branch_cost: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ready_o && issue_i && dec.cond |=>
    info_o.cycles == $past(dec.cycles) + {3'h0, $past(cond_taken_i)})
    else $error("branch cost wrong");
  chk_full_count: assert property (@(posedge clk_i) disable iff (!nrst_i)
    done_o |-> run_q == info_o.cycles && ready_o)
    else $error("instruction did not hold its count");
  chk_flash_target: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ready_o && issue_i && dec.cls == CLS_XMOVE &&
    opcode_i[7:4] == HI_XWRITE && flash_wr_en_i |=> info_o.xtgt == XT_FLASH)
    else $error("flash write target wrong");

endmodule : bci_timing

// File: bci_prog_mem.sv
// Program memory model that hands opcodes to the instruction timing block.
// Assumes the bench drives the fetch slot number in step with the clock.
`timescale 1ns/1ns

module bci_prog_mem (
  input wire logic [5:0] addr_i,
  output logic [7:0] opcode_o
);
  // Fixed test program; the bench picks each instruction by slot number.
  localparam logic [7:0] ROM [0:32] = '{
    8'h28, 8'h26, 8'hA4, 8'h84, 8'h93, 8'h83, 8'hE2, 8'hF2, 8'hE0, 8'hF0,
    8'h90, 8'hA3, 8'h53, 8'h85, 8'hF6, 8'hA6, 8'h76, 8'hD6, 8'hC0, 8'hD0,
    8'hE4, 8'hD4, 8'hC4, 8'hC2, 8'hC3, 8'h12, 8'h22, 8'h32, 8'hA5, 8'h00,
    8'h40, 8'h20, 8'hB6};

  // Slots past the program return a fixed filler byte.
  assign opcode_o = (addr_i <= 6'd32) ? ROM[addr_i] : 8'hFF;
endmodule : bci_prog_mem

// File: byte_cpu_instruction_timing_test.sv
// Self-checking bench for the instruction decode and timing block.
// Assumes the design package is compiled first and one clock drives all.
`timescale 1ns/1ns

module byte_cpu_instruction_timing_test;
  import bci_pkg::*;

  logic clk;
  logic nrst;
  logic issue;
  logic cond_taken;
  logic external_space_ram_onchip;
  logic flash_wr_en;
  logic [5:0] pc;
  logic [7:0] opcode;
  logic ready;
  logic done;
  bci_info_t info;
  bci_info_t nop_info;
  int fails;
  int samples_checked;

  // Program memory on the fetch side and the block under test.
  bci_prog_mem mem (.addr_i(pc), .opcode_o(opcode));
  bci_timing uut (.clk_i(clk), .nrst_i(nrst), .issue_i(issue),
    .opcode_i(opcode), .cond_taken_i(cond_taken),
    .external_space_ram_onchip_i(external_space_ram_onchip), .flash_wr_en_i(flash_wr_en),
    .ready_o(ready), .done_o(done), .info_o(info));

  // The 20 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Compares one value and reports a difference at once.
  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Issues one slot and counts clock cycles until the done pulse.
  task automatic run(input logic [5:0] a, input logic c,
      input logic [1:0] b, input logic [3:0] n);
    int k;
    k = 0;
    check("ready_idle", ready, 1'b1);
    @(posedge clk);
    pc <= a;
    cond_taken <= c;
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    do begin
      @(negedge clk);
      k++;
      if (k == 1) check("ready_busy", ready, n == 4'h1);
    end while (done !== 1'b1 && k < 20);
    check("cycles_seen", k, n);
    check("info_cycles", info.cycles, n);
    check("info_bytes", info.bytes, b);
    if (k >= 20) summarize();
  endtask : run

  // Accumulator, multiply, divide and pointer increment timing.
  task automatic arith_timing();
    run(6'd0, 1'b0, LEN_1, CYC_1);
    run(6'd1, 1'b0, LEN_1, CYC_2);
    run(6'd2, 1'b0, LEN_1, CYC_4);
    run(6'd3, 1'b0, LEN_1, CYC_8);
    run(6'd11, 1'b0, LEN_1, CYC_1);
    run(6'd20, 1'b0, LEN_1, CYC_1);
    run(6'd21, 1'b0, LEN_1, CYC_1);
    run(6'd22, 1'b0, LEN_1, CYC_1);
  endtask : arith_timing

  // Code reads, pointer load, direct and indirect moves, stack.
  task automatic moves();
    run(6'd4, 1'b0, LEN_1, CYC_3);
    run(6'd5, 1'b0, LEN_1, CYC_3);
    run(6'd10, 1'b0, LEN_3, CYC_3);
    run(6'd12, 1'b0, LEN_3, CYC_3);
    run(6'd13, 1'b0, LEN_3, CYC_3);
    run(6'd14, 1'b0, LEN_1, CYC_2);
    run(6'd15, 1'b0, LEN_2, CYC_2);
    run(6'd16, 1'b0, LEN_2, CYC_2);
    run(6'd17, 1'b0, LEN_1, CYC_2);
    run(6'd18, 1'b0, LEN_2, CYC_2);
    run(6'd19, 1'b0, LEN_2, CYC_2);
  endtask : moves

  // Bit operations, carry operations, call and returns.
  task automatic bool_calls();
    run(6'd23, 1'b0, LEN_2, CYC_2);
    run(6'd24, 1'b0, LEN_1, CYC_1);
    run(6'd25, 1'b0, LEN_3, CYC_4);
    run(6'd26, 1'b0, LEN_1, CYC_5);
    run(6'd27, 1'b0, LEN_1, CYC_5);
  endtask : bool_calls

  // Untaken branches finish one cycle before taken ones.
  task automatic branches();
    run(6'd30, 1'b0, LEN_2, CYC_2);
    check("taken", info.taken, 1'b0);
    check("cond", info.cond, 1'b1);
    run(6'd30, 1'b1, LEN_2, CYC_3);
    check("taken", info.taken, 1'b1);
    run(6'd31, 1'b0, LEN_3, CYC_3);
    check("cond", info.cond, 1'b1);
    check("taken", info.taken, 1'b0);
    run(6'd31, 1'b1, LEN_3, CYC_4);
    run(6'd32, 1'b0, LEN_3, CYC_4);
    run(6'd32, 1'b1, LEN_3, CYC_5);
  endtask : branches

  // The spare opcode must look exactly like the defined no-operation.
  task automatic spare();
    run(6'd29, 1'b0, LEN_1, CYC_1);
    nop_info = info;
    run(6'd28, 1'b0, LEN_1, CYC_1);
    check("spare_info", info, nop_info);
    check("spare_cls", info.cls, CLS_NOP);
    check("spare_cond", info.cond, 1'b0);
    check("spare_xtgt", info.xtgt, XT_NONE);
  endtask : spare

  // One external move with the given target selects.
  task automatic xcase(input logic on, input logic fl, input logic [5:0] a,
      input bci_xtgt_t t, input logic w);
    @(posedge clk);
    external_space_ram_onchip <= on;
    flash_wr_en <= fl;
    run(a, 1'b0, LEN_1, CYC_3);
    check("xtgt", info.xtgt, t);
    check("xwrite", info.xwrite, w);
  endtask : xcase

  // External moves reach on-chip RAM, off-chip memory or flash.
  task automatic ext_targets();
    xcase(1'b1, 1'b0, 6'd8, XT_ONCHIP, 1'b0);
    xcase(1'b0, 1'b0, 6'd6, XT_OFFCHIP, 1'b0);
    xcase(1'b0, 1'b1, 6'd9, XT_FLASH, 1'b1);
    xcase(1'b1, 1'b0, 6'd7, XT_ONCHIP, 1'b1);
    xcase(1'b0, 1'b1, 6'd8, XT_OFFCHIP, 1'b0);
  endtask : ext_targets

  // Multiply then add with issue held high; requests while busy are ignored.
  task automatic back_to_back();
    logic [4:0] d;
    d = '0;
    @(posedge clk);
    pc <= 6'd2;
    issue <= 1'b1;
    @(posedge clk);
    pc <= 6'd0;
    repeat (4) begin
      @(negedge clk);
      d = {d[3:0], done};
    end
    @(posedge clk);
    issue <= 1'b0;
    @(negedge clk);
    d = {d[3:0], done};
    check("b2b_done", d, 5'h03);
    check("b2b_cycles", info.cycles, CYC_1);
  endtask : back_to_back

  // A reset in the middle of a divide returns the block to idle.
  task automatic reset_mid();
    @(posedge clk);
    pc <= 6'd3;
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    @(posedge clk);
    nrst <= 1'b0;
    @(negedge clk);
    check("rst_ready", ready, 1'b1);
    check("rst_done", done, 1'b0);
    check("rst_info", info, '0);
    @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
  endtask : reset_mid

  // Main sequence: reset, then every scenario in turn.
  initial begin
    fails = 0;
    samples_checked = 0;
    nrst = 1'b0;
    issue = 1'b0;
    pc = '0;
    cond_taken = 1'b0;
    external_space_ram_onchip = 1'b0;
    flash_wr_en = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    arith_timing();
    moves();
    bool_calls();
    branches();
    spare();
    ext_targets();
    back_to_back();
    reset_mid();
    summarize();
  end
endmodule : byte_cpu_instruction_timing_test
